// [pab_lh_flag.sv]
// latched-high status flag: set by an event, cleared by a read
`timescale 1ns/1ps
`default_nettype none

module pab_latched_high_flag (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_set,
    input wire logic i_rd_clr,
    output logic o_flag
);

    // ==========================================================
    // flag
    logic flag;
    logic next_flag;

    // set beats a clear in the same cycle so no event is lost
    always_comb begin
        next_flag = flag;
        if (i_rd_clr) begin
            next_flag = 1'b0;
        end
        if (i_set) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

    assign o_flag = flag;

endmodule : pab_latched_high_flag

`default_nettype wire

// [pab_link_partner.sv]
// partner model: remote link partner feeding received pages and events
`timescale 1ns/1ps
`default_nettype none
module pab_link_partner
    import pab_pkg::*;
#(
    parameter int NUM_PORTS = 4
) (
    input wire logic i_sys_clk,
    output pab_pkg::pab_link_in_t [NUM_PORTS-1:0] o_link
);
    initial o_link = '0;
    // ==========================================================
    // events pulse one cycle; the base page word stays as a level
    task automatic pulse(input int p, input int kind, input logic [15:0] word);
        @(negedge i_sys_clk);
        if (kind == 0) o_link[p].lp_base = word;
        o_link[p].page_rx = (kind == 0);
        o_link[p].pd_fault = (kind == 1);
        o_link[p].np_sent = (kind == 2);
        @(negedge i_sys_clk);
        o_link[p].page_rx = 1'b0;
        o_link[p].pd_fault = 1'b0;
        o_link[p].np_sent = 1'b0;
    endtask : pulse
    task automatic levels(input int p, input logic able, input logic done);
        @(negedge i_sys_clk);
        o_link[p].lp_an_able = able;
        o_link[p].an_complete = done;
    endtask : levels
endmodule : pab_link_partner
`default_nettype wire

// [pab_page_regs.sv]
// per-port auto-negotiation page registers behind the management access port
//
// What this block does
// - advertisement bit 15 is writable next-page capability, reset zero
// - advertisement bit 13 is writable remote-fault capability; bits 14, 12 read zero
// - advertisement pause field 11:10 writable, resets to symmetric pause code 01
// - advertisement bit 9 (T4 ability) is read-only and always zero
// - bits 8:5 writable resetting to one; selector 4:0 writable resetting to 00001
// - partner register read-only, shows received base page; bit 14 marks word received
// - partner register bit 13 shows partner-signalled remote fault
// - expansion bit 4 latches parallel-detection fault until read
// - expansion bit 3 reports partner next-page capability
// - expansion bit 2 is read-only constant one
// - expansion bit 1 latches new page received until read
// - expansion bit 0 shows partner auto-negotiation ability; bits 15:5 read zero
// - next-page bit 15 writable, reset zero, marks more pages follow
// - next-page bit 13 message/unformatted resets one; message field 10:0 resets 0x001
// - next-page bit 12 writable, reset zero, will-comply acknowledge
// - next-page bit 11 read-only toggle of the previous transmitted word, reset zero
// - basic status bit 5 reports auto-negotiation complete
`timescale 1ns/1ps
`default_nettype none

module pab_page_regs #(
    parameter int NUM_PORTS = pab_pkg::PAB_NUM_PORTS
) (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire pab_pkg::pab_req_t i_req,
    input wire pab_pkg::pab_link_in_t [NUM_PORTS-1:0] i_link,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_ack,
    output logic o_reg_hit,
    output pab_pkg::pab_link_out_t [NUM_PORTS-1:0] o_link,
    output logic [NUM_PORTS-1:0] o_an_complete
);
    import pab_pkg::*;

    // ==========================================================
    // parameter check
    // the port field is one nibble and port numbers start at one
    if (NUM_PORTS < 1 || NUM_PORTS > 15) begin : gen_bad_ports
        $error("pab_page_regs: NUM_PORTS must be 1 to 15");
    end

    // ==========================================================
    // address decode
    logic [PAB_PORT_W-1:0] port_nib;
    logic [11:0] local_ofs;
    logic odd_addr;
    logic is_bstat;
    logic is_adv;
    logic is_lpa;
    logic is_exp;
    logic is_np;
    logic [NUM_PORTS-1:0] port_sel;
    logic any_reg;

    assign port_nib = i_req.addr[PAB_PORT_LSB +: PAB_PORT_W];
    assign local_ofs = i_req.addr[11:0];
    // a register is reached at its even byte address only
    assign odd_addr = i_req.addr[0];

    assign is_bstat = (local_ofs == (OFS_BASIC_STATUS[11:0] & PAB_LOCAL_MASK));
    assign is_adv = (local_ofs == (OFS_ADVERTISE[11:0] & PAB_LOCAL_MASK));
    assign is_lpa = (local_ofs == (OFS_PARTNER_BASE[11:0] & PAB_LOCAL_MASK));
    assign is_exp = (local_ofs == (OFS_EXPANSION[11:0] & PAB_LOCAL_MASK));
    assign is_np = (local_ofs == (OFS_NEXT_PAGE[11:0] & PAB_LOCAL_MASK));

    assign any_reg = !odd_addr && (is_bstat || is_adv || is_lpa || is_exp || is_np);

    // port N sits at nibble N, so port index p answers to nibble p+1
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : gen_sel
            localparam logic [PAB_PORT_W-1:0] NIB = PAB_PORT_W'(gp + 1);
            assign port_sel[gp] = any_reg && (port_nib == NIB);
        end
    endgenerate

    // ==========================================================
    // per-port register copies
    logic [15:0] rd_word [NUM_PORTS];

    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : gen_port

            logic wr_adv;
            logic wr_np;
            logic rd_exp;
            logic adv_np;
            logic adv_rf;
            logic [ADV_PAUSE_W-1:0] adv_pause;
            logic [ADV_TECH_W-1:0] adv_tech;
            logic [ADV_SEL_W-1:0] adv_sel;
            logic [15:0] adv;
            logic np_more;
            logic np_msg;
            logic np_ack2;
            logic [NP_FIELD_W-1:0] np_field;
            logic toggle;
            logic [15:0] lp_base;
            logic lp_an_able;
            logic an_done;
            logic pd_fault_flag;
            logic page_rx_flag;
            logic [15:0] exp_word;
            logic [15:0] np_word;
            logic [15:0] bstat_word;

            assign wr_adv = i_req.wr && port_sel[gp] && is_adv;
            assign wr_np = i_req.wr && port_sel[gp] && is_np;
            assign rd_exp = i_req.rd && port_sel[gp] && is_exp;

            // ------------------------------------------------------
            // advertisement: one flop group per field; T4 and reserved bits have none
            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    adv_np <= ADV_RST[ADV_NP_BIT];
                end else if (wr_adv) begin
                    adv_np <= i_req.wdata[ADV_NP_BIT];
                end
            end

            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    adv_rf <= ADV_RST[ADV_RF_BIT];
                end else if (wr_adv) begin
                    adv_rf <= i_req.wdata[ADV_RF_BIT];
                end
            end

            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    adv_pause <= ADV_RST[ADV_PAUSE_LSB +: ADV_PAUSE_W];
                end else if (wr_adv) begin
                    adv_pause <= i_req.wdata[ADV_PAUSE_LSB +: ADV_PAUSE_W];
                end
            end

            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    adv_tech <= ADV_RST[ADV_TECH_LSB +: ADV_TECH_W];
                end else if (wr_adv) begin
                    adv_tech <= i_req.wdata[ADV_TECH_LSB +: ADV_TECH_W];
                end
            end

            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    adv_sel <= ADV_RST[ADV_SEL_LSB +: ADV_SEL_W];
                end else if (wr_adv) begin
                    adv_sel <= i_req.wdata[ADV_SEL_LSB +: ADV_SEL_W];
                end
            end

            // bits with no flop read zero, so no write can ever set them
            always_comb begin
                adv = 16'h0000;
                adv[ADV_NP_BIT] = adv_np;
                adv[ADV_RF_BIT] = adv_rf;
                adv[ADV_PAUSE_LSB +: ADV_PAUSE_W] = adv_pause;
                adv[ADV_TECH_LSB +: ADV_TECH_W] = adv_tech;
                adv[ADV_SEL_LSB +: ADV_SEL_W] = adv_sel;
            end

            // ------------------------------------------------------
            // next page: writable fields, one flop group each
            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    np_more <= NP_RST[NP_MORE_BIT];
                end else if (wr_np) begin
                    np_more <= i_req.wdata[NP_MORE_BIT];
                end
            end

            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    np_msg <= NP_RST[NP_MSG_BIT];
                end else if (wr_np) begin
                    np_msg <= i_req.wdata[NP_MSG_BIT];
                end
            end

            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    np_ack2 <= NP_RST[NP_ACK2_BIT];
                end else if (wr_np) begin
                    np_ack2 <= i_req.wdata[NP_ACK2_BIT];
                end
            end

            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    np_field <= NP_RST[NP_FIELD_LSB +: NP_FIELD_W];
                end else if (wr_np) begin
                    np_field <= i_req.wdata[NP_FIELD_LSB +: NP_FIELD_W];
                end
            end

            // ------------------------------------------------------
            // toggle flips after each next page leaves; software cannot write it
            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    toggle <= 1'b0;
                end else if (i_link[gp].np_sent) begin
                    toggle <= ~toggle;
                end
            end

            // ------------------------------------------------------
            // partner state sampled from the negotiation engine
            // one cycle of latency keeps the read mux off the link inputs
            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    lp_base <= 16'h0000;
                end else begin
                    lp_base <= i_link[gp].lp_base;
                end
            end

            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    lp_an_able <= 1'b0;
                end else begin
                    lp_an_able <= i_link[gp].lp_an_able;
                end
            end

            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    an_done <= 1'b0;
                end else begin
                    an_done <= i_link[gp].an_complete;
                end
            end

            // ------------------------------------------------------
            // latched-high flags, cleared by a read of the expansion word
            pab_latched_high_flag u_pd_fault (
                .i_sys_clk(i_sys_clk),
                .i_srst(i_srst),
                .i_set(i_link[gp].pd_fault),
                .i_rd_clr(rd_exp),
                .o_flag(pd_fault_flag)
            );

            pab_latched_high_flag u_page_rx (
                .i_sys_clk(i_sys_clk),
                .i_srst(i_srst),
                .i_set(i_link[gp].page_rx),
                .i_rd_clr(rd_exp),
                .o_flag(page_rx_flag)
            );

            // ------------------------------------------------------
            // read words
            always_comb begin
                exp_word = 16'h0000;
                exp_word[EXP_PD_FAULT_BIT] = pd_fault_flag;
                exp_word[EXP_LP_NP_BIT] = lp_base[LPA_NP_BIT];
                exp_word[EXP_NP_ABLE_BIT] = 1'b1;
                exp_word[EXP_PAGE_RX_BIT] = page_rx_flag;
                exp_word[EXP_LP_AN_BIT] = lp_an_able;
            end

            // reserved bit 14 has no flop and reads zero
            always_comb begin
                np_word = 16'h0000;
                np_word[NP_MORE_BIT] = np_more;
                np_word[NP_MSG_BIT] = np_msg;
                np_word[NP_ACK2_BIT] = np_ack2;
                np_word[NP_TOGGLE_BIT] = toggle;
                np_word[NP_FIELD_LSB +: NP_FIELD_W] = np_field;
            end

            always_comb begin
                bstat_word = BSTAT_FIXED;
                bstat_word[BSTAT_AN_DONE_BIT] = an_done;
            end

            always_comb begin
                rd_word[gp] = 16'h0000;
                if (is_adv) begin
                    rd_word[gp] = adv;
                end else if (is_lpa) begin
                    rd_word[gp] = lp_base;
                end else if (is_exp) begin
                    rd_word[gp] = exp_word;
                end else if (is_np) begin
                    rd_word[gp] = np_word;
                end else if (is_bstat) begin
                    rd_word[gp] = bstat_word;
                end
            end

            // ------------------------------------------------------
            // words driven toward the line side come straight from flops
            assign o_link[gp].adv_word = adv;
            assign o_link[gp].np_word = np_word;
            assign o_an_complete[gp] = an_done;
        end
    endgenerate

    // ==========================================================
    // read data mux
    logic [15:0] next_rdata;

    // port_sel is one-hot, so an OR over the gated words picks one port
    always_comb begin
        next_rdata = 16'h0000;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (port_sel[p]) begin
                next_rdata = next_rdata | rd_word[p];
            end
        end
    end

    // ==========================================================
    // answer
    // every request is answered one cycle later, mapped or not;
    // unmapped reads return zero and unmapped writes are dropped
    logic [15:0] rdata;
    logic ack;
    logic hit;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rdata <= 16'h0000;
        end else if (i_req.rd) begin
            rdata <= next_rdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ack <= 1'b0;
            hit <= 1'b0;
        end else begin
            ack <= i_req.rd || i_req.wr;
            hit <= (i_req.rd || i_req.wr) && (|port_sel);
        end
    end

    assign o_reg_rdata = rdata;
    assign o_reg_ack = ack;
    assign o_reg_hit = hit;

endmodule : pab_page_regs

`default_nettype wire

// [pab_page_regs_checker.sv]
// checker: access protocol and field assertions for the page register block
`timescale 1ns/1ps
`default_nettype none
module pab_page_regs_checker
    import pab_pkg::*;
#(
    parameter int NUM_PORTS = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire pab_pkg::pab_req_t i_req,
    input wire pab_pkg::pab_link_in_t [NUM_PORTS-1:0] i_link,
    input wire logic [15:0] o_reg_rdata,
    input wire logic o_reg_ack,
    input wire logic o_reg_hit,
    input wire pab_pkg::pab_link_out_t [NUM_PORTS-1:0] o_link,
    input wire logic [NUM_PORTS-1:0] o_an_complete
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    // ==========================================================
    // helper decode
    logic req;
    logic mapped;
    logic [11:0] ofs;
    assign req = i_req.rd | i_req.wr;
    assign ofs = i_req.addr[11:0];
    assign mapped = (i_req.addr[15:12] != 4'h0) && (i_req.addr[15:12] <= NUM_PORTS)
        && (ofs inside {12'h102, 12'h108, 12'h10A, 12'h10C, 12'h10E});
    // ==========================================================
    // assertions
    AST_ACK: assert property (req |=> o_reg_ack)
        else $error("request not answered next cycle");
    AST_IDLE: assert property (!req |=> !o_reg_ack && !o_reg_hit)
        else $error("ack or hit without request");
    AST_HIT: assert property (req |=> o_reg_hit == $past(mapped))
        else $error("hit does not match address decode");
    AST_MISS_ZERO: assert property (i_req.rd && !mapped |=> o_reg_rdata == 16'h0000)
        else $error("unmapped read returned data");
    AST_RD_HOLD: assert property (!i_req.rd |=> $stable(o_reg_rdata))
        else $error("read data moved without a read");
    AST_ADV_RSV: assert property (i_req.rd && mapped && ofs == 12'h108 |=>
        (o_reg_rdata & 16'h5200) == 16'h0000) else $error("reserved advert bits set");
    AST_T4_ZERO: assert property ((o_link[0].adv_word & 16'h5200) == 16'h0000)
        else $error("advert read-only bits not zero");
    AST_EXP_FIXED: assert property (i_req.rd && mapped && ofs == 12'h10C |=>
        o_reg_rdata[15:5] == 11'h000 && o_reg_rdata[2]) else $error("expansion fixed bits");
    AST_ADV_WRITE: assert property (i_req.wr && i_req.addr == 16'h1108 |=>
        o_link[0].adv_word == ($past(i_req.wdata) & ADV_WR_MASK))
        else $error("advert write not applied");
    AST_NP_WRITE: assert property (i_req.wr && i_req.addr == 16'h110E |=>
        (o_link[0].np_word & NP_WR_MASK) == ($past(i_req.wdata) & NP_WR_MASK))
        else $error("next page write not applied");
    AST_TOGGLE: assert property (i_link[0].np_sent |-> ##[1:2]
        $changed(o_link[0].np_word[NP_TOGGLE_BIT])) else $error("toggle did not flip");
    cover property (i_link[0].page_rx);
    cover property (i_req.rd && !mapped);
    cover property (i_req.wr && mapped);
endmodule : pab_page_regs_checker

bind pab_page_regs pab_page_regs_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_req(i_req), .i_link(i_link),
    .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack), .o_reg_hit(o_reg_hit),
    .o_link(o_link), .o_an_complete(o_an_complete));
`default_nettype wire

// [pab_page_regs_tb.sv]
// testbench: register access, partner events and decode of the page registers
`timescale 1ns/1ps
`default_nettype none
module pab_page_regs_tb;
    import pab_pkg::*;
    typedef struct packed {
        logic chk;
        logic [15:0] data;
        logic hit;
    } pab_note_t;
    logic i_sys_clk;
    logic i_srst;
    pab_req_t i_req;
    pab_link_in_t [3:0] i_link;
    logic [15:0] o_reg_rdata;
    logic o_reg_ack;
    logic o_reg_hit;
    pab_link_out_t [3:0] o_link;
    logic [3:0] o_an_complete;
    pab_note_t notes[$];
    pab_note_t n;
    int err_total = 0;
    int check_count = 0;
    integer seed = 32'h949d1f16;
    logic [15:0] adv_m [4];
    logic [15:0] np_m [4];
    logic [15:0] w;
    logic [15:0] bad [4] = '{16'h5108, 16'h0108, 16'h1109, 16'h1104};

    pab_page_regs #(.NUM_PORTS(4)) u_dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
        .i_req(i_req), .i_link(i_link), .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack),
        .o_reg_hit(o_reg_hit), .o_link(o_link), .o_an_complete(o_an_complete));
    pab_link_partner #(.NUM_PORTS(4)) u_lp (.i_sys_clk(i_sys_clk), .o_link(i_link));

    // ==========================================================
    // shared tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // request stays up into the next call, so accesses run back to back
    task automatic acc(input logic rd, input logic [15:0] a, input logic [15:0] wd,
        input logic [15:0] exp, input logic hit);
        @(negedge i_sys_clk);
        i_req = '{rd: rd, wr: !rd, addr: a, wdata: wd};
        notes.push_back('{chk: rd, data: exp, hit: hit});
    endtask : acc
    task automatic idle(input int k);
        @(negedge i_sys_clk);
        i_req = '0;
        repeat (k) @(negedge i_sys_clk);
    endtask : idle
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    // ==========================================================
    // clock, monitor and watchdog
    initial begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    always @(negedge i_sys_clk) begin
        if (o_reg_ack === 1'b1) begin
            if (notes.size() == 0) begin
                chk({15'h0, o_reg_ack}, 16'h0000);
            end else begin
                n = notes.pop_front();
                chk({15'h0, o_reg_hit}, {15'h0, n.hit});
                if (n.chk) chk(o_reg_rdata, n.data);
            end
        end
    end
    initial begin
        repeat (5000) @(posedge i_sys_clk);
        err_total++;
        give_verdict();
    end

    // ==========================================================
    // main sequence
    initial begin
        i_srst = 1'b1;
        i_req = '0;
        repeat (16) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_srst = 1'b0;
        for (int p = 1; p <= 4; p++) begin
            acc(1, {4'(p), 12'h108}, 0, ADV_RST, 1);
            acc(1, {4'(p), 12'h10A}, 0, 16'h0000, 1);
            acc(1, {4'(p), 12'h10C}, 0, 16'h0004, 1);
            acc(1, {4'(p), 12'h10E}, 0, NP_RST, 1);
            acc(1, {4'(p), 12'h102}, 0, BSTAT_FIXED, 1);
            chk(o_link[p-1].adv_word, ADV_RST);
            chk(o_link[p-1].np_word, NP_RST);
            chk({15'h0, o_an_complete[p-1]}, 16'h0000);
        end
        $display("test reset values done");
        // one pause code per port; distinct words prove the copies are separate
        for (int p = 1; p <= 4; p++) begin
            w = 16'($random(seed));
            w[11:10] = 2'(p - 1);
            adv_m[p-1] = w & ADV_WR_MASK;
            acc(0, {4'(p), 12'h108}, w, 0, 1);
            w = 16'($random(seed));
            np_m[p-1] = w & NP_WR_MASK;
            acc(0, {4'(p), 12'h10E}, w, 0, 1);
            acc(0, {4'(p), 12'h10A}, 16'hFFFF, 0, 1);
        end
        for (int p = 1; p <= 4; p++) begin
            acc(1, {4'(p), 12'h108}, 0, adv_m[p-1], 1);
            acc(1, {4'(p), 12'h10E}, 0, np_m[p-1], 1);
            acc(1, {4'(p), 12'h10A}, 0, 16'h0000, 1);
            chk(o_link[p-1].adv_word, adv_m[p-1]);
        end
        $display("test writes done");
        for (int p = 0; p < 4; p++) begin
            idle(0);
            w = 16'($random(seed));
            w[14] = 1'b1;
            w[13] = p[0];
            u_lp.levels(p, 1'b1, p[1]);
            u_lp.pulse(p, 0, w);
            u_lp.pulse(p, 1, 0);
            u_lp.pulse(p, 2, 0);
            idle(2);
            chk({15'h0, o_an_complete[p]}, {15'h0, p[1]});
            acc(1, {4'(p + 1), 12'h10A}, 0, w, 1);
            acc(1, {4'(p + 1), 12'h10C}, 0, {11'h0, 1'b1, w[15], 3'h7}, 1);
            acc(1, {4'(p + 1), 12'h10C}, 0, {11'h0, 1'b0, w[15], 3'h5}, 1);
            acc(1, {4'(p + 1), 12'h10E}, 0, np_m[p] | 16'h0800, 1);
            acc(1, {4'(p + 1), 12'h102}, 0, BSTAT_FIXED | {10'h0, p[1], 5'h0}, 1);
        end
        $display("test partner events done");
        for (int i = 0; i < 4; i++) begin
            acc(1, bad[i], 0, 16'h0000, 0);
            acc(0, bad[i], 16'hFFFF, 0, 0);
        end
        acc(1, 16'h1108, 0, adv_m[0], 1);
        idle(4);
        chk(16'(notes.size()), 16'h0000);
        $display("test unmapped access done");
        give_verdict();
    end
endmodule : pab_page_regs_tb
`default_nettype wire

// [pab_pkg.sv]
// package: register map, field layout and carriers of the auto-negotiation page registers
package pab_pkg;

    // ==========================================================
    // widths and address layout
    localparam int PAB_DW = 16;
    localparam int PAB_AW = 16;
    localparam int PAB_PORT_LSB = 12;
    localparam int PAB_PORT_W = 4;
    localparam int PAB_NUM_PORTS = 4;
    localparam logic [11:0] PAB_LOCAL_MASK = 12'hFFF;

    // ==========================================================
    // register offsets (port 1 copy; the top nibble picks the port)
    localparam logic [15:0] OFS_BASIC_STATUS = 16'h1102;
    localparam logic [15:0] OFS_ADVERTISE = 16'h1108;
    localparam logic [15:0] OFS_PARTNER_BASE = 16'h110A;
    localparam logic [15:0] OFS_EXPANSION = 16'h110C;
    localparam logic [15:0] OFS_NEXT_PAGE = 16'h110E;

    // ==========================================================
    // advertisement fields
    localparam int ADV_NP_BIT = 15;
    localparam int ADV_RF_BIT = 13;
    localparam int ADV_PAUSE_LSB = 10;
    localparam int ADV_T4_BIT = 9;
    localparam int ADV_SEL_LSB = 0;
    localparam int ADV_PAUSE_W = 2;
    localparam int ADV_TECH_LSB = 5;
    localparam int ADV_TECH_W = 4;
    localparam int ADV_SEL_W = 5;
    localparam logic [15:0] ADV_WR_MASK = 16'hADFF;
    localparam logic [15:0] ADV_RST = 16'h05E1;
    localparam logic [1:0] PAUSE_NONE = 2'h0;
    localparam logic [1:0] PAUSE_SYM = 2'h1;
    localparam logic [1:0] PAUSE_ASYM_PARTNER = 2'h2;
    localparam logic [1:0] PAUSE_BOTH_LOCAL = 2'h3;

    // ==========================================================
    // partner base page fields
    localparam int LPA_NP_BIT = 15;
    localparam int LPA_ACK_BIT = 14;
    localparam int LPA_RF_BIT = 13;

    // ==========================================================
    // expansion status fields
    localparam int EXP_PD_FAULT_BIT = 4;
    localparam int EXP_LP_NP_BIT = 3;
    localparam int EXP_NP_ABLE_BIT = 2;
    localparam int EXP_PAGE_RX_BIT = 1;
    localparam int EXP_LP_AN_BIT = 0;

    // ==========================================================
    // next page fields
    localparam int NP_MORE_BIT = 15;
    localparam int NP_MSG_BIT = 13;
    localparam int NP_ACK2_BIT = 12;
    localparam int NP_TOGGLE_BIT = 11;
    localparam int NP_FIELD_LSB = 0;
    localparam int NP_FIELD_W = 11;
    localparam logic [15:0] NP_WR_MASK = 16'hB7FF;
    localparam logic [15:0] NP_RST = 16'h2001;

    // ==========================================================
    // basic status: fixed ability bits and the live completion bit
    localparam logic [15:0] BSTAT_FIXED = 16'h7849;
    localparam int BSTAT_AN_DONE_BIT = 5;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pab_req_t;

    typedef struct packed {
        logic [15:0] lp_base;
        logic page_rx;
        logic pd_fault;
        logic lp_an_able;
        logic an_complete;
        logic np_sent;
    } pab_link_in_t;

    typedef struct packed {
        logic [15:0] adv_word;
        logic [15:0] np_word;
    } pab_link_out_t;

endpackage : pab_pkg
